// ### hdl/cpu_operand_addressing.v
// Operand addressing, program counter and low-power control for the CPU.
`timescale 1ns/10ps
`include "cpu_operand_addressing_defs.vh"
module cpu_operand_addressing (
    input wire clk_in,
    input wire rst_in,
    input wire instr_valid_in,
    input wire [2:0] mode_in,
    input wire [7:0] opcode_in,
    input wire [7:0] operand_hi_in,
    input wire [7:0] operand_lo_in,
    input wire [1:0] instr_len_in,
    input wire branch_taken_in,
    input wire jump_in,
    input wire wait_instr_in,
    input wire stop_instr_in,
    input wire interrupt_event_in,
    input wire background_req_in,
    input wire debug_cmd_in,
    input wire debug_go_in,
    input wire shadow_load_in,
    input wire alu_en_in,
    input wire alu_op_in,
    input wire [7:0] mem_data_in,
    input wire index_write_in,
    input wire [7:0] index_wdata_in,
    output reg [13:0] mem_addr_out,
    output reg [5:0] pc_upper_part_out,
    output reg [7:0] pc_lower_part_out,
    output reg [5:0] saved_pc_upper_out,
    output reg [7:0] saved_pc_lower_out,
    output reg [7:0] acc_out,
    output reg carry_flag_out,
    output reg [7:0] index_value_out,
    output wire cpu_clk_en_out,
    output wire fetch_en_out,
    output wire [1:0] cpu_state_out,
    output reg wake_pending_out
);
    localparam ST_RUN = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_STOP = 2'h2;
    localparam ST_BDM = 2'h3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [13:0] pc_reg;
    reg [13:0] pc_next;
    wire [13:0] next_pc;
    wire [13:0] raw_addr;
    wire [7:0] sum;
    wire sum_carry;
    wire running;

    assign running = (state_reg == ST_RUN);
    // Clocks run in normal and background modes; fetch runs only in normal operation.
    assign cpu_clk_en_out = running || (state_reg == ST_BDM);
    assign fetch_en_out = running;
    assign cpu_state_out = state_reg;
    assign next_pc = pc_reg + {12'h000, instr_len_in};

    operand_address_former u_addr (
        .mode_in(mode_in),
        .opcode_in(opcode_in),
        .operand_hi_in(operand_hi_in),
        .operand_lo_in(operand_lo_in),
        .index_value_in(index_value_out),
        .next_pc_in(next_pc),
        .raw_addr_out(raw_addr)
    );

    accumulator_adder u_add (
        .op_in(alu_op_in),
        .acc_in(acc_out),
        .mem_in(mem_data_in),
        .carry_in(carry_flag_out),
        .sum_out(sum),
        .carry_out(sum_carry)
    );

    // Mode sequencing; interrupts never redirect flow, they only wake.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (background_req_in) begin
                    state_next = ST_BDM;
                end else if (instr_valid_in && stop_instr_in) begin
                    state_next = ST_STOP;
                end else if (instr_valid_in && wait_instr_in) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT, ST_STOP: begin
                if (interrupt_event_in) begin
                    state_next = ST_RUN;
                end
            end
            ST_BDM: begin
                if (debug_cmd_in && debug_go_in) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    // Next program counter: branch, jump or sequential.
    always @* begin
        pc_next = pc_reg;
        if (running && instr_valid_in && !wait_instr_in && !stop_instr_in) begin
            if ((mode_in == `MODE_RELATIVE) && branch_taken_in) begin
                pc_next = raw_addr;
            end else if ((mode_in == `MODE_EXTENDED) && jump_in) begin
                pc_next = raw_addr;
            end else begin
                pc_next = next_pc;
            end
        end
    end

    // Core state; reset restarts execution at the reset vector.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_RUN;
            pc_reg <= `PC_RESET_VALUE;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
        end
    end

    // Split counter views for the upper and lower parts.
    always @* begin
        pc_upper_part_out = pc_reg[13:8];
        pc_lower_part_out = pc_reg[7:0];
    end

    // Address issue; the data window redirects through the index byte.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_addr_out <= 14'h0000;
        end else if (running && instr_valid_in) begin
            if (raw_addr == `WINDOW_ADDR && mode_in != `MODE_RELATIVE &&
                mode_in != `MODE_EXTENDED) begin
                mem_addr_out <= {6'h00, index_value_out};
            end else begin
                mem_addr_out <= raw_addr;
            end
        end
    end

    // Index byte lives at 0x000f and behaves as plain memory.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            index_value_out <= 8'h00;
        end else if (running && index_write_in) begin
            index_value_out <= index_wdata_in;
        end
    end

    // Shadow counter copies the next counter value with the same split.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            saved_pc_upper_out <= 6'h00;
            saved_pc_lower_out <= 8'h00;
        end else if (running && shadow_load_in) begin
            saved_pc_upper_out <= next_pc[13:8];
            saved_pc_lower_out <= next_pc[7:0];
        end
    end

    // Accumulator update; suspended while clocks are gated.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_out <= 8'h00;
            carry_flag_out <= 1'b0;
        end else if (running && alu_en_in) begin
            acc_out <= sum;
            carry_flag_out <= sum_carry;
        end
    end

    // Polled interrupt flag; a new event wins over the clear.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_pending_out <= 1'b0;
        end else if (interrupt_event_in) begin
            wake_pending_out <= 1'b1;
        end else if (running && instr_valid_in) begin
            wake_pending_out <= 1'b0;
        end
    end
endmodule // cpu_operand_addressing

// ### hdl/cpu_operand_addressing_defs.vh
// Constants for the operand addressing and low-power control block.
// Overview of operation
// - Halt-and-wait enters wait, halt-and-stop enters stop.
// - Low-power state gates CPU clocks, suspends activity.
// - Interrupt or reset wakes CPU from low power.
// - Background mode idles until debug command with go arrives.
// - Pseudo index register is memory byte 0x000f.
// - Access to 0x000e redirects to index location; the code leaves extended and relative mode addresses of 0x000e unchanged.
// - Tiny mode address from low four opcode bits.
// - Short mode address from low five opcode bits.
// - Direct mode uses operand byte, high byte zero.
// - Extended address: two bytes, fourteen bits total.
// - Branch target is next address plus signed offset.
// - Add-with-carry sums accumulator, operand and carry.
// - Plain add sums accumulator and operand only.
// - Program counter split six high, eight low.
// - Shadow counter has the same six/eight split.
// - Tiny address zero-extended by ten zero bits.
// - Run-mode interrupts only polled, wake from low power.
// - After reset the counter loads 0x3ffd.
`ifndef CPU_OPERAND_ADDRESSING_DEFS_VH
`define CPU_OPERAND_ADDRESSING_DEFS_VH
`define ADDR_W 14
`define PC_HI_W 6
`define PC_LO_W 8
`define PC_RESET_VALUE 14'h3ffd
`define INDEX_ADDR 14'h000f
`define WINDOW_ADDR 14'h000e
`define MODE_TINY 3'h0
`define MODE_SHORT 3'h1
`define MODE_DIRECT 3'h2
`define MODE_EXTENDED 3'h3
`define MODE_INDEXED 3'h4
`define MODE_RELATIVE 3'h5
`define ALU_ADD 1'b0
`define ALU_ADC 1'b1
`endif

// ### hdl/operand_address_former.v
// Combinational formation of 14-bit operand addresses from instruction fields.
`timescale 1ns/10ps
`include "cpu_operand_addressing_defs.vh"
module operand_address_former (
    input wire [2:0] mode_in,
    input wire [7:0] opcode_in,
    input wire [7:0] operand_hi_in,
    input wire [7:0] operand_lo_in,
    input wire [7:0] index_value_in,
    input wire [13:0] next_pc_in,
    output reg [13:0] raw_addr_out
);
    // Expand each mode's field; unknown modes fall back to address zero.
    always @* begin
        case (mode_in)
            `MODE_TINY: raw_addr_out = {10'h000, opcode_in[3:0]};
            `MODE_SHORT: raw_addr_out = {9'h000, opcode_in[4:0]};
            `MODE_DIRECT: raw_addr_out = {6'h00, operand_lo_in};
            `MODE_EXTENDED: raw_addr_out = {operand_hi_in[5:0], operand_lo_in};
            `MODE_INDEXED: raw_addr_out = {6'h00, index_value_in};
            `MODE_RELATIVE: raw_addr_out = next_pc_in +
                {{6{operand_lo_in[7]}}, operand_lo_in};
            default: raw_addr_out = 14'h0000;
        endcase
    end
endmodule // operand_address_former

// ### hdl/accumulator_adder.v
// Eight-bit adder for the plain add and add-with-carry instructions.
`timescale 1ns/10ps
`include "cpu_operand_addressing_defs.vh"
module accumulator_adder (
    input wire op_in,
    input wire [7:0] acc_in,
    input wire [7:0] mem_in,
    input wire carry_in,
    output wire [7:0] sum_out,
    output wire carry_out
);
    wire use_carry;
    wire [8:0] total;
    // Plain add ignores the incoming carry entirely.
    assign use_carry = (op_in == `ALU_ADC) ? carry_in : 1'b0;
    assign total = {1'b0, acc_in} + {1'b0, mem_in} + {8'h00, use_carry};
    assign sum_out = total[7:0];
    assign carry_out = total[8];
endmodule // accumulator_adder

// ### verification/cpu_operand_addressing_checker.sv
// Port-level checker for the operand addressing block.
`timescale 1ns/10ps
module cpu_operand_addressing_checker (
    input wire clk_in, input wire rst_in, input wire instr_valid_in,
    input wire [2:0] mode_in, input wire [7:0] opcode_in,
    input wire [7:0] operand_hi_in, input wire [7:0] operand_lo_in,
    input wire wait_instr_in, input wire stop_instr_in,
    input wire interrupt_event_in, input wire background_req_in,
    input wire alu_en_in, input wire alu_op_in, input wire [7:0] mem_data_in,
    input wire [13:0] mem_addr_out, input wire [5:0] pc_upper_part_out,
    input wire [7:0] pc_lower_part_out, input wire [7:0] acc_out,
    input wire carry_flag_out, input wire cpu_clk_en_out,
    input wire fetch_en_out, input wire [1:0] cpu_state_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Debug entry wins, so a request alongside it is not counted as taken.
    wire take = instr_valid_in && cpu_state_out == 2'h0 && !background_req_in;
    wire halt = cpu_state_out == 2'h1 || cpu_state_out == 2'h2;
    wire [3:0] tiny_f = opcode_in[3:0];
    wire [5:0] hi_f = operand_hi_in[5:0];
    a_wait_entry: assert property (
        take && wait_instr_in && !stop_instr_in |=> cpu_state_out == 2'h1)
        else $error("wait state not entered");
    a_stop_entry: assert property (
        take && stop_instr_in && !wait_instr_in |=> cpu_state_out == 2'h2)
        else $error("stop state not entered");
    a_clocks_gated: assert property (
        halt |-> !cpu_clk_en_out && !fetch_en_out)
        else $error("clocks run while halted");
    a_halt_holds: assert property (
        halt && !interrupt_event_in && !background_req_in
        |=> $stable(cpu_state_out)) else $error("left halt without wake");
    a_wake_up: assert property (
        halt && interrupt_event_in |=> cpu_state_out == 2'h0)
        else $error("no wake on event");
    a_debug_idle: assert property (
        cpu_state_out == 2'h3 |-> !fetch_en_out)
        else $error("fetch during debug idle");
    a_tiny_addr: assert property (
        take && mode_in == 3'h0 && tiny_f != 4'he
        |=> mem_addr_out == {10'h0, $past(tiny_f)})
        else $error("tiny address wrong");
    a_ext_addr: assert property (
        take && mode_in == 3'h3
        |=> mem_addr_out == {$past(hi_f), $past(operand_lo_in)})
        else $error("extended address wrong");
    a_add_plain: assert property (
        take && alu_en_in && !alu_op_in |=> {carry_flag_out, acc_out} ==
        $past(acc_out) + $past(mem_data_in)) else $error("add sum wrong");
    a_add_carry: assert property (
        take && alu_en_in && alu_op_in |=> {carry_flag_out, acc_out} ==
        $past(acc_out) + $past(mem_data_in) + $past(carry_flag_out))
        else $error("add with carry sum wrong");
    a_reset_pc: assert property (
        $fell(rst_in) |-> {pc_upper_part_out, pc_lower_part_out} == 14'h3ffd)
        else $error("counter not at start address");
    c_wake: cover property (halt && interrupt_event_in);
    c_debug: cover property (cpu_state_out == 2'h3);
    c_carry_add: cover property (take && alu_en_in && alu_op_in);
endmodule // cpu_operand_addressing_checker

bind cpu_operand_addressing cpu_operand_addressing_checker checker_i (.*);

// ### verification/cpu_operand_addressing_test.sv
// Directed testbench for the operand addressing block.
`timescale 1ns/10ps
module cpu_operand_addressing_test;
    logic clk_in = 0, rst_in = 1, instr_valid_in = 0, branch_taken_in = 0;
    logic jump_in = 0, wait_instr_in = 0, stop_instr_in = 0, alu_op_in = 0;
    logic interrupt_event_in = 0, background_req_in = 0, debug_cmd_in = 0;
    logic debug_go_in = 0, shadow_load_in = 0, alu_en_in = 0;
    logic index_write_in = 0, carry_flag_out, cpu_clk_en_out, fetch_en_out;
    logic wake_pending_out;
    logic [1:0] instr_len_in = 2'h1, cpu_state_out;
    logic [2:0] mode_in = 3'h0;
    logic [7:0] opcode_in = 8'h0, operand_hi_in = 8'h0, operand_lo_in = 8'h0;
    logic [7:0] mem_data_in = 8'h0, index_wdata_in = 8'h0, acc_out;
    logic [7:0] pc_lower_part_out, saved_pc_lower_out, index_value_out;
    logic [5:0] pc_upper_part_out, saved_pc_upper_out;
    logic [13:0] mem_addr_out, epc = 14'h3ffd;
    int fails = 0, comparisons = 0, cycles = 0;
    cpu_operand_addressing cpu_operand_addressing_i (.*);
    always #2 clk_in = ~clk_in;
    // The whole run needs about 55 cycles, so this cuts only a hang.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            finish_test;
        end
    end
    task automatic finish_test;
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic clk1;
        @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Issues one instruction; the expected counter follows the same step.
    // An idle edge follows, so the next call never re-raises a strobe at
    // the instant this one lowered it.
    task automatic run(input logic [2:0] m, input logic [7:0] op, hi, lo,
        input logic [1:0] len);
        logic h;
        h = wait_instr_in | stop_instr_in;
        mode_in = m;
        opcode_in = op;
        operand_hi_in = hi;
        operand_lo_in = lo;
        instr_len_in = len;
        instr_valid_in = 1;
        epc = jump_in ? {hi[5:0], lo} : epc + len;
        if (branch_taken_in) epc = epc + {{6{lo[7]}}, lo};
        clk1;
        instr_valid_in = 0;
        {jump_in, branch_taken_in, alu_en_in, shadow_load_in} = 4'h0;
        {wait_instr_in, stop_instr_in, interrupt_event_in} = 3'h0;
        if (!h) chk({pc_upper_part_out, pc_lower_part_out}, epc);
        clk1;
    endtask
    task automatic t_modes;
        chk({pc_upper_part_out, pc_lower_part_out}, 14'h3ffd);
        run(3'h0, 8'h6f, 8'h0, 8'h0, 2'h1);
        chk(mem_addr_out, 14'h000f);
        run(3'h1, 8'hff, 8'h0, 8'h0, 2'h1);
        chk(mem_addr_out, 14'h001f);
        run(3'h2, 8'h0, 8'h77, 8'hff, 2'h2);
        chk(mem_addr_out, 14'h00ff);
        run(3'h3, 8'h0, 8'hff, 8'h34, 2'h3);
        chk(mem_addr_out, 14'h3f34);
        index_write_in = 1;
        index_wdata_in = 8'h5a;
        clk1;
        index_write_in = 0;
        chk({6'h0, index_value_out}, 14'h005a);
        run(3'h4, 8'h0, 8'h0, 8'h0, 2'h1);
        chk(mem_addr_out, 14'h005a);
        run(3'h0, 8'h6e, 8'h0, 8'h0, 2'h1);
        chk(mem_addr_out, 14'h005a);
    endtask
    // Carry is set before a plain add to show that it is ignored there.
    task automatic t_alu;
        logic [7:0] d [6] = '{8'hff, 8'h01, 8'h05, 8'hff, 8'h01, 8'h10};
        logic [8:0] e [6] = '{9'h0ff, 9'h100, 9'h005, 9'h104, 9'h006, 9'h016};
        for (int i = 0; i < 6; i++) begin
            alu_en_in = 1;
            alu_op_in = i > 3;
            mem_data_in = d[i];
            run(3'h2, 8'h0, 8'h0, 8'h20, 2'h2);
            chk({5'h0, carry_flag_out, acc_out}, {5'h0, e[i]});
        end
    endtask
    task automatic t_flow;
        jump_in = 1;
        run(3'h3, 8'h0, 8'h0, 8'h10, 2'h3);
        branch_taken_in = 1;
        run(3'h5, 8'h0, 8'h0, 8'h80, 2'h2);
        branch_taken_in = 1;
        run(3'h5, 8'h0, 8'h0, 8'h7f, 2'h2);
        shadow_load_in = 1;
        run(3'h0, 8'h60, 8'h0, 8'h0, 2'h1);
        chk({saved_pc_upper_out, saved_pc_lower_out}, epc);
        interrupt_event_in = 1;
        run(3'h0, 8'h61, 8'h0, 8'h0, 2'h1);
        chk({12'h0, cpu_state_out}, 14'h0);
        chk({13'h0, wake_pending_out}, 14'h1);
    endtask
    task automatic t_halt;
        for (int i = 0; i < 2; i++) begin
            wait_instr_in = i == 0;
            stop_instr_in = i == 1;
            run(3'h0, 8'h60, 8'h0, 8'h0, 2'h1);
            chk({12'h0, cpu_state_out}, i ? 14'h2 : 14'h1);
            chk({13'h0, cpu_clk_en_out | fetch_en_out}, 14'h0);
            clk1;
            chk({12'h0, cpu_state_out}, i ? 14'h2 : 14'h1);
            interrupt_event_in = 1;
            clk1;
            interrupt_event_in = 0;
            chk({12'h0, cpu_state_out}, 14'h0);
            jump_in = 1;
            run(3'h3, 8'h0, 8'h01, 8'h20, 2'h3);
        end
    endtask
    task automatic t_debug;
        background_req_in = 1;
        clk1;
        background_req_in = 0;
        debug_cmd_in = 1;
        chk({11'h0, fetch_en_out, cpu_state_out}, 14'h3);
        clk1;
        chk({12'h0, cpu_state_out}, 14'h3);
        debug_go_in = 1;
        clk1;
        {debug_cmd_in, debug_go_in} = 2'h0;
        chk({12'h0, cpu_state_out}, 14'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 0;
        t_modes;
        t_alu;
        t_flow;
        t_halt;
        t_debug;
        finish_test;
    end
endmodule // cpu_operand_addressing_test
